/* File: test/atic_cmd_engine_props.sv */
// Checker for the command engine: reply timing, codes and timer pulses.
// Assumes a steady clock enable and the engine's own port names.
`timescale 1ns/100ps
module atic_props (
    input wire logic        ref_clk_i,
    input wire logic        srst_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_ready_o,
    input wire logic [15:0] host_command_code_word_i,
    input wire logic [15:0] host_param_word_first_i,
    input wire logic        adapter_open_i,
    input wire logic        link_control_layer_en_i,
    input wire logic        host_iframe_opt_i,
    input wire logic        rebuild_req_i,
    input wire logic [7:0]  rebuild_corr_i,
    input wire logic [15:0] adapter_reply_code_word_o,
    input wire logic [15:0] reply_param_word_first_o,
    input wire logic [15:0] reply_param_word_second_o,
    input wire logic        cmd_status_irq_o,
    input wire logic        cmd_reject_irq_o,
    input wire logic        timer_irq_o,
    input wire logic        timer_running_o,
    input wire logic        build_req_o,
    input wire logic [7:0]  build_corr_o
);
    import atic_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Accepted commands by kind, and the frame grant conditions.
    wire tk  = cmd_valid_i && cmd_ready_o;
    wire en  = link_control_layer_en_i;
    wire tmr = tk && host_command_code_word_i == CMD_TIMER;
    wire frm = tk && host_command_code_word_i == CMD_IFRAME;
    wire ok  = adapter_open_i && en && host_iframe_opt_i;
    wire nz  = |host_param_word_first_i[7:0];
    sequence s_done(logic [15:0] c);
        ##3 cmd_status_irq_o && !cmd_reject_irq_o
            && adapter_reply_code_word_o == c;
    endsequence
    sequence s_refuse;
        ##3 cmd_reject_irq_o && !cmd_status_irq_o;
    endsequence
    a_timer_reply:
    assert property (tmr && en |-> s_done(CMD_TIMER)
        ##0 reply_param_word_first_o == ST_GOOD) else $error("timer reply");
    a_timer_refuse:
    assert property (tmr && !en |-> s_refuse) else $error("timer refuse");
    a_frame_refuse:
    assert property (frm && !ok |-> s_refuse) else $error("frame refuse");
    a_frame_echo:
    assert property (frm && ok |-> s_done(CMD_IFRAME) ##0
        reply_param_word_second_o == $past(host_param_word_first_i, 3))
        else $error("frame echo");
    a_timer_run:
    assert property (tmr && en |-> ##3 timer_running_o == $past(nz, 3))
        else $error("timer run state");
    a_timer_quiet:
    assert property (timer_irq_o |-> timer_running_o
        || $past(timer_running_o)) else $error("timer pulse while off");
    a_build_pass:
    assert property (rebuild_req_i |=> build_req_o
        && build_corr_o == $past(rebuild_corr_i)) else $error("build req");
    a_reply_hold:
    assert property (!cmd_status_irq_o |-> $stable(reply_param_word_first_o))
        else $error("reply word moved");
endmodule
bind atic_cmd_engine atic_props atic_props_inst (.*);

/* File: test/atic_host_model.sv */
// Host model: posts command blocks and keeps frame correlators queued.
// Assumes the engine takes the block at an edge where ready is high.
`timescale 1ns/100ps
module atic_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic       cmd_ready_i,
    input  wire logic       build_req_i,
    input  wire logic [7:0] build_corr_i,
    output logic            cmd_valid_o,
    output logic [15:0]     code_o,
    output logic [15:0]     p0_o,
    output logic [15:0]     p1_o,
    output int              miss_o
);
    logic [7:0] corr_q[$];
    // Idle block before the first post.
    initial
    begin
        cmd_valid_o = 1'b0;
        {code_o, p0_o, p1_o} = '0;
        miss_o = 0;
    end
    // Hold the block until taken, then scramble the released words.
    task automatic post(input logic [15:0] c, p0, p1);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b1;
        code_o <= c;
        p0_o <= p0;
        p1_o <= p1;
        do @(negedge ref_clk_i); while (cmd_ready_i !== 1'b1);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b0;
        code_o <= ~c;
        p0_o <= ~p0;
        p1_o <= ~p1;
    endtask
    // Granted correlators stay queued for repeated builds.
    task automatic keep(input logic [7:0] c);
        corr_q.push_back(c);
    endtask
    // Every build request must name a queued frame.
    always @(posedge ref_clk_i)
        if (build_req_i === 1'b1 && !(build_corr_i inside {corr_q}))
            miss_o <= miss_o + 1;
endmodule

/* File: test/tb_atic_cmd_engine.sv */
// Testbench for the command engine: timer and frame request commands.
// Assumes the host model posts blocks and a 20 MHz reference clock.
`timescale 1ns/100ps
module tb_atic_cmd_engine;
    import atic_pkg::*;
    localparam int TK = 10;
    logic        ref_clk = 1'b0, srst = 1'b1, open_lv = 1'b0;
    logic        en_lv = 1'b0, opt_lv = 1'b0, ack = 1'b0, rb = 1'b0;
    logic [15:0] vld = '0, snd = '0, dfr = '0;
    logic [3:0]  ack_stn = '0;
    logic [7:0]  rb_corr = '0, bcorr;
    logic        valid, ready, sirq, rirq, tirq, trun, breq;
    logic [15:0] code, p0, p1, rcode, r0, r1, r2;
    int          miss, err_total = 0, tests_run = 0, seed = 34;
    int          outs[16], corr_m = 0, s, n;
    atic_cmd_engine #(.TICK_CYC(TK)) atic_cmd_engine_inst (
        .ref_clk_i(ref_clk), .srst_i(srst), .ce_i(1'b1),
        .cmd_valid_i(valid), .cmd_ready_o(ready),
        .host_command_code_word_i(code), .host_param_word_first_i(p0),
        .host_param_word_second_i(p1), .adapter_open_i(open_lv),
        .link_control_layer_en_i(en_lv), .host_iframe_opt_i(opt_lv),
        .station_valid_i(vld), .station_can_send_i(snd),
        .station_defer_i(dfr), .frame_ack_i(ack), .frame_ack_stn_i(ack_stn),
        .rebuild_req_i(rb), .rebuild_corr_i(rb_corr),
        .adapter_reply_code_word_o(rcode), .reply_param_word_first_o(r0),
        .reply_param_word_second_o(r1), .reply_param_word_third_o(r2),
        .cmd_status_irq_o(sirq), .cmd_reject_irq_o(rirq),
        .timer_irq_o(tirq), .timer_running_o(trun),
        .build_req_o(breq), .build_corr_o(bcorr));
    atic_host_model host_inst (
        .ref_clk_i(ref_clk), .cmd_ready_i(ready), .build_req_i(breq),
        .build_corr_i(bcorr), .cmd_valid_o(valid), .code_o(code),
        .p0_o(p0), .p1_o(p1), .miss_o(miss));
    // Free-running reference clock.
    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Post one command and compare the reply with the reference model.
    task automatic run(input logic [15:0] c, a);
        logic [15:0] e;
        logic        rej, acc;
        int          k;
        host_inst.post(c, a, 16'($random(seed)));
        k = a[3:0];
        rej = !en_lv || (c != CMD_TIMER
              && (c != CMD_IFRAME || !open_lv || !opt_lv));
        e = c == CMD_TIMER ? ST_GOOD : !vld[k] ? ST_BAD_STATION
            : !snd[k] ? ST_PROTO_ERR : outs[k] >= MAX_OUTSTANDING
            ? ST_MAX_OUT : dfr[k] ? ST_DEFERRED : ST_GOOD;
        acc = !rej && c == CMD_IFRAME && (e == ST_GOOD || e == ST_DEFERRED);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reject irq", rej, rirq);
        chk("status irq", !rej, sirq);
        if (!rej)
            chk("reply code", c, rcode);
        if (!rej)
            chk("status", e, r0);
        if (acc)
        begin
            chk("station", a, r1);
            chk("corr", {corr_m[7:0], 8'h00}, r2);
            host_inst.keep(corr_m[7:0]);
            corr_m++;
            outs[k]++;
        end
    endtask
    // Measure the spacing of two timer pulses.
    task automatic per(input int e);
        n = 0;
        while (tirq !== 1'b1 && n < 3000) begin @(negedge ref_clk); n++; end
        n = 0;
        do begin @(negedge ref_clk); n++; end while (tirq !== 1'b1 && n < 3000);
        chk("period", 16'(e), 16'(n));
    endtask
    // Main sequence: timer, frame grants, refusals, rebuilds.
    initial
    begin
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        run(CMD_TIMER, 16'h0003);
        en_lv <= 1'b1;
        run(CMD_TIMER, {8'($random(seed)), 8'h03});
        per(3 * TK);
        run(CMD_TIMER, 16'h0005);
        per(5 * TK);
        run(CMD_TIMER, 16'h00ff);
        per(255 * TK);
        run(CMD_TIMER, 16'h0000);
        n = 0;
        repeat (700) begin @(negedge ref_clk); n += tirq; end
        chk("stopped pulses", 16'h0000, 16'(n));
        {open_lv, opt_lv} <= 2'b11;
        vld <= 16'($random(seed)) & 16'h7fff | 16'h4001;
        snd <= 16'($random(seed)) & 16'hbfff | 16'h0001;
        dfr <= 16'($random(seed)) & 16'hfffe;
        for (int i = 0; i < 60; i++)
        begin
            s = i < 2 ? 14 + i : $random(seed) & 15;
            if (!(dfr[s] && outs[s] > 0))
                run(CMD_IFRAME, 16'(s));
        end
        // Fill station 0 to its outstanding limit, then expect the max-outstanding status.
        while (outs[0] < MAX_OUTSTANDING)
            run(CMD_IFRAME, 16'h0000);
        run(CMD_IFRAME, 16'h0000);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        outs[0]--;
        run(CMD_IFRAME, 16'h0000);
        repeat (2)
        begin
            rb <= 1'b1;
            rb_corr <= 8'(corr_m - 1);
            @(posedge ref_clk);
            rb <= 1'b0;
            @(negedge ref_clk);
            chk("build corr", {breq, 7'h00, bcorr}, {1'b1, 7'h00, 8'(corr_m - 1)});
            @(posedge ref_clk);
        end
        for (int k = 0; k < 3; k++)
        begin
            {open_lv, opt_lv, en_lv} <= 3'b111 ^ (3'b001 << k);
            run(CMD_IFRAME, 16'h0001);
        end
        run(16'h0030, 16'h0000);
        chk("missed corr", 16'h0000, 16'(miss));
        final_report();
    end
    // Watchdog cuts a hang short.
    initial
    begin
        #(50 * 40000);
        err_total++;
        final_report();
    end
endmodule

/* File: verilog/atic_cmd_engine.sv */
// Command engine for the interval timer and frame transmit request commands.
// Assumes the host holds a command block stable while cmd_valid_i is high
// and that link state inputs are synchronous to ref_clk_i.
`timescale 1ns/100ps
module atic_cmd_engine #(
    parameter int STATIONS = 16,
    parameter int TICK_CYC = atic_pkg::TICK_CYC
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      srst_i,
    input  wire logic                      ce_i,
    input  wire logic                      cmd_valid_i,
    output logic                           cmd_ready_o,
    input  wire logic [15:0]               host_command_code_word_i,
    input  wire logic [15:0]               host_param_word_first_i,
    input  wire logic [15:0]               host_param_word_second_i,
    input  wire logic                      adapter_open_i,
    input  wire logic                      link_control_layer_en_i,
    input  wire logic                      host_iframe_opt_i,
    input  wire logic [STATIONS-1:0]       station_valid_i,
    input  wire logic [STATIONS-1:0]       station_can_send_i,
    input  wire logic [STATIONS-1:0]       station_defer_i,
    input  wire logic                      frame_ack_i,
    input  wire logic [atic_pkg::STN_W-1:0] frame_ack_stn_i,
    input  wire logic                      rebuild_req_i,
    input  wire logic [7:0]                rebuild_corr_i,
    output logic [15:0]                    adapter_reply_code_word_o,
    output logic [15:0]                    reply_param_word_first_o,
    output logic [15:0]                    reply_param_word_second_o,
    output logic [15:0]                    reply_param_word_third_o,
    output logic                           cmd_status_irq_o,
    output logic                           cmd_reject_irq_o,
    output logic                           timer_irq_o,
    output logic                           timer_running_o,
    output logic                           build_req_o,
    output logic [7:0]                     build_corr_o
);
    import atic_pkg::*;
    initial if (STATIONS < 1 || STATIONS > (1 << STN_W))
        $error("STATIONS out of range");

    atic_state_t state_r;
    atic_state_t state_nxt;
    logic [15:0] code_r;
    logic [15:0] p0_r;
    logic [15:0] status_r;
    logic        reject_r;

    // Decode of the command and its acceptance conditions.
    wire [STN_W-1:0] stn      = p0_r[STN_W-1:0];
    wire             is_timer = (code_r == CMD_TIMER);
    wire             is_ifr   = (code_r == CMD_IFRAME);
    wire [7:0]       tcount   = p0_r[COUNT_LSB +: COUNT_W];
    wire             stn_ok   = (p0_r[15:STN_W] == '0) &&
                                (32'(stn) < STATIONS) &&
                                station_valid_i[stn];
    wire             t_rej    = !link_control_layer_en_i;
    wire             i_rej    = !adapter_open_i ||
                                !link_control_layer_en_i ||
                                !host_iframe_opt_i;
    wire             bad_cmd  = !is_timer && !is_ifr;
    wire             do_rej   = bad_cmd || (is_timer && t_rej) ||
                                (is_ifr && i_rej);
    wire             full;
    wire [7:0]       corr;
    wire             can_send = stn_ok && station_can_send_i[stn];
    wire             accept   = is_ifr && !do_rej && can_send && !full;
    wire             exec     = (state_r == ST_EXEC) && ce_i;
    wire             t_load   = exec && is_timer && !do_rej;

    // Status selection for the frame request, in priority order.
    wire [15:0] ifr_status =
        !stn_ok                ? ST_BAD_STATION :
        !station_can_send_i[stn] ? ST_PROTO_ERR :
        full                   ? ST_MAX_OUT :
        station_defer_i[stn]   ? ST_DEFERRED :
                                 ST_GOOD;

    atic_interval_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .load_i    (t_load),
        .count_i   (tcount),
        .running_o (timer_running_o),
        .expire_o  (timer_irq_o)
    );

    atic_corr_table #(
        .STATIONS (STATIONS),
        .SW       (STN_W)
    ) u_corr (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .stn_i     (stn),
        .take_i    (exec && accept),
        .ack_stn_i (frame_ack_stn_i),
        .ack_i     (frame_ack_i),
        .full_o    (full),
        .corr_o    (corr)
    );

    // Next state of the command sequence.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:  if (cmd_valid_i) state_nxt = ST_EXEC;
            ST_EXEC:  state_nxt = ST_REPLY;
            ST_REPLY: state_nxt = ST_IDLE;
            default:  state_nxt = ST_IDLE;
        endcase
    end
    assign cmd_ready_o = (state_r == ST_IDLE);

    // Command capture and state register.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            state_r  <= ST_IDLE;
            code_r   <= 16'h0000;
            p0_r     <= 16'h0000;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            if (cmd_valid_i && cmd_ready_o)
            begin
                code_r <= host_command_code_word_i;
                p0_r   <= host_param_word_first_i;   // second word unused
            end
        end
    end

    // Latch the outcome of the executed command.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            status_r <= 16'h0000;
            reject_r <= 1'b0;
        end
        else if (exec)
        begin
            reject_r <= do_rej;
            status_r <= is_timer ? ST_GOOD : ifr_status;
        end
    end

    // Status block write and the completion or reject pulse.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            adapter_reply_code_word_o <= 16'h0000;
            reply_param_word_first_o  <= 16'h0000;
            reply_param_word_second_o <= 16'h0000;
            reply_param_word_third_o  <= 16'h0000;
            cmd_status_irq_o          <= 1'b0;
            cmd_reject_irq_o          <= 1'b0;
        end
        else if (ce_i)
        begin
            cmd_status_irq_o <= 1'b0;
            cmd_reject_irq_o <= 1'b0;
            if (state_r == ST_REPLY)
            begin
                cmd_reject_irq_o <= reject_r;
                cmd_status_irq_o <= !reject_r;
                if (!reject_r)
                begin
                    adapter_reply_code_word_o <= code_r;
                    reply_param_word_first_o  <= status_r;
                    reply_param_word_second_o <= is_ifr ? p0_r : 16'h0000;
                    reply_param_word_third_o  <=
                        (is_ifr && (status_r == ST_GOOD ||
                                    status_r == ST_DEFERRED))
                        ? {corr - 8'h01, 8'h00} : 16'h0000;
                end
            end
        end
    end

    // Build requests name the frame by correlator, repeats allowed.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            build_req_o  <= 1'b0;
            build_corr_o <= 8'h00;
        end
        else if (ce_i)
        begin
            build_req_o <= rebuild_req_i;
            if (rebuild_req_i)
                build_corr_o <= rebuild_corr_i;
        end
    end
endmodule

/* File: verilog/atic_corr_table.sv */
// Per-station outstanding-frame counters with a shared correlator counter.
// Assumes at most one assign and one acknowledge per cycle.
`timescale 1ns/100ps
module atic_corr_table #(
    parameter int STATIONS = 16,
    parameter int SW       = 4
) (
    input  wire logic          ref_clk_i,
    input  wire logic          srst_i,
    input  wire logic          ce_i,
    input  wire logic [SW-1:0] stn_i,
    input  wire logic          take_i,
    input  wire logic [SW-1:0] ack_stn_i,
    input  wire logic          ack_i,
    output logic               full_o,
    output logic [7:0]         corr_o
);
    import atic_pkg::*;
    initial if (STATIONS > (1 << SW)) $error("STATIONS exceeds index");

    logic [OUT_W-1:0] cnt_r [STATIONS];
    logic [7:0]       corr_r;

    // One outstanding counter per link station.
    genvar g;
    for (g = 0; g < STATIONS; g++)
    begin : g_stn
        wire inc = take_i && (stn_i == SW'(g));
        wire dec = ack_i && (ack_stn_i == SW'(g)) && (cnt_r[g] != '0);
        always_ff @(posedge ref_clk_i)
        begin
            if (srst_i)
                cnt_r[g] <= '0;
            else if (ce_i && (inc != dec))
                cnt_r[g] <= inc ? cnt_r[g] + 1'b1 : cnt_r[g] - 1'b1;
        end
    end

    // Correlator advances on every accepted request.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
            corr_r <= 8'h00;
        else if (ce_i && take_i)
            corr_r <= corr_r + 8'h01;
    end
    assign full_o = (cnt_r[stn_i] == OUT_W'(MAX_OUTSTANDING));
    assign corr_o = corr_r;
endmodule

/* File: verilog/atic_interval_timer.sv */
// Periodic interval timer: prescaler to 10 ms ticks and a period counter.
// Assumes load pulses come from the command engine in one cycle.
`timescale 1ns/100ps
module atic_interval_timer #(
    parameter int TICK_CYC = 200000
) (
    input  wire logic       ref_clk_i,
    input  wire logic       srst_i,
    input  wire logic       ce_i,
    input  wire logic       load_i,
    input  wire logic [7:0] count_i,
    output logic            running_o,
    output logic            expire_o
);
    import atic_pkg::*;
    localparam int PW = $clog2(TICK_CYC);
    initial if (TICK_CYC < 2) $error("TICK_CYC too small");

    logic [PW-1:0] pre_r;
    logic [7:0]    per_r;
    logic [7:0]    left_r;
    logic          run_r;
    wire           tick    = (pre_r == PW'(TICK_CYC - 1));
    wire           last    = tick && (left_r == 8'h01);

    // A load restarts from zero; a zero count stops the timer.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            pre_r    <= '0;
            per_r    <= 8'h00;
            left_r   <= 8'h00;
            run_r    <= 1'b0;
            expire_o <= 1'b0;
        end
        else if (ce_i)
        begin
            expire_o <= 1'b0;
            if (load_i)
            begin
                pre_r  <= '0;
                per_r  <= count_i;
                left_r <= count_i;
                run_r  <= (count_i != 8'h00);
            end
            else if (run_r)
            begin
                pre_r <= tick ? '0 : pre_r + 1'b1;
                if (last)
                begin
                    left_r   <= per_r;
                    expire_o <= 1'b1;
                end
                else if (tick)
                    left_r <= left_r - 8'h01;
            end
        end
    end
    assign running_o = run_r;
endmodule

/* File: verilog/atic_pkg.sv */
// Package with codes, field positions and timing counts for the adapter
// timer and frame-request command block.
// Assumes a 20 MHz reference clock.
package atic_pkg;
    localparam int          CLK_HZ          = 20000000;
    localparam int          TICK_MS         = 10;
    localparam int          TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
    localparam logic [15:0] CMD_TIMER       = 16'h0022;
    localparam logic [15:0] CMD_IFRAME      = 16'h0023;
    localparam logic [15:0] ST_GOOD         = 16'h0000;
    localparam logic [15:0] ST_MAX_OUT      = 16'h0025;
    localparam logic [15:0] ST_BAD_STATION  = 16'h0040;
    localparam logic [15:0] ST_PROTO_ERR    = 16'h0041;
    localparam logic [15:0] ST_DEFERRED     = 16'h00ff;
    localparam int          MAX_OUTSTANDING = 127;
    localparam int          COUNT_LSB       = 0;
    localparam int          COUNT_W         = 8;
    localparam int          CORR_LSB        = 8;
    localparam int          STN_W           = 4;
    localparam int          OUT_W           = 7;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_REPLY = 2'b10
    } atic_state_t;
endpackage
